// [rtl/charger_regs_pkg.sv]
// constants, register map and types shared by the charger register bank
package charger_regs_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] LIMIT_REG_ADDR   = 8'h09;
  localparam logic [7:0] MONITOR_REG_ADDR = 8'h0A;
  localparam logic [7:0] VINREG_ADDR      = 8'h0B;

  localparam logic [7:0] LIMIT_REG_RST    = 8'h0A;
  localparam logic [7:0] VINREG_RST       = 8'h4A;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // writable storage bits; everything else is command or reads zero
  localparam logic [7:0] LIMIT_WR_MASK    = 8'h3F;
  localparam logic [7:0] VINREG_WR_MASK   = 8'hFE;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SOFT_RST_BIT  = 7;
  localparam int ILIM_LSB      = 3;
  localparam int UVLO_LSB      = 0;
  localparam int MON_REQ_BIT   = 7;
  localparam int BAND_LSB      = 5;
  localparam int FINE_LSB      = 2;
  localparam int VLOOP_OFF_BIT = 7;
  localparam int VLOOP_LSB     = 4;
  localparam int HALF_BIT      = 3;
  localparam int TMR_LSB       = 1;

  // ****************************************************************
  // decode values
  // ****************************************************************
  localparam logic [9:0]  ILIM_BASE_MA  = 10'h032;
  localparam logic [9:0]  ILIM_STEP_MA  = 10'h032;
  localparam logic [12:0] VLOOP_BASE_MV = 13'h1068;
  localparam logic [12:0] VLOOP_STEP_MV = 13'h0064;
  localparam logic [11:0] UVLO_3000_MV  = 12'hBB8;
  localparam logic [11:0] UVLO_2800_MV  = 12'hAF0;
  localparam logic [11:0] UVLO_2600_MV  = 12'hA28;
  localparam logic [11:0] UVLO_2400_MV  = 12'h960;
  localparam logic [11:0] UVLO_2200_MV  = 12'h898;
  localparam logic [11:0] UVLO_RSVD_MV  = 12'h000;
  localparam logic [2:0]  UVLO_C3000    = 3'h2;
  localparam logic [2:0]  UVLO_C2800    = 3'h3;
  localparam logic [2:0]  UVLO_C2600    = 3'h4;
  localparam logic [2:0]  UVLO_C2400    = 3'h5;
  localparam logic [2:0]  UVLO_C2200A   = 3'h6;
  localparam logic [2:0]  UVLO_C2200B   = 3'h7;

  // ****************************************************************
  // battery monitor search
  // ****************************************************************
  localparam logic [1:0] BAND_TOP    = 2'h3;
  localparam logic [1:0] BAND_BOTTOM = 2'h0;
  localparam logic [2:0] FINE_NONE   = 3'h0;
  localparam int CLK_NS      = 50;
  localparam int SETTLE_NS   = 1000;
  localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] SETTLE_LAST = 5'(SETTLE_CYC - 1);

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_SETTLE = 2'b01,
    S_SAMPLE = 2'b10
  } search_state_type;

  // ****************************************************************
  // safety timer
  // ****************************************************************
  localparam int CLK_HZ     = 20_000_000;
  localparam int TICK_S     = 1;
  localparam int TICK_CYC   = TICK_S * CLK_HZ;
  localparam int TICK_W     = 25;
  localparam logic [1:0]  TMR_30MIN = 2'h0;
  localparam logic [1:0]  TMR_3H    = 2'h1;
  localparam logic [1:0]  TMR_9H    = 2'h2;
  localparam logic [1:0]  TMR_OFF   = 2'h3;
  localparam logic [15:0] LIMIT_30MIN_S = 16'h0708;
  localparam logic [15:0] LIMIT_3H_S    = 16'h2A30;
  localparam logic [15:0] LIMIT_9H_S    = 16'h7E90;

endpackage

// [rtl/monitor_if.sv]
// link between the register bank and the battery monitor search engine
`timescale 1ns/1ns
interface monitor_if (
  input wire logic clk,
  input wire logic rst
);
  logic       start;
  logic [2:0] fine_meas;
  logic       busy;
  logic [1:0] band;
  logic       done;
  logic [1:0] result_band;
  logic [2:0] result_fine;

  modport search (
    input  clk, rst, start, fine_meas,
    output busy, band, done, result_band, result_fine
  );
  modport ctrl (
    input  clk, rst, busy, band, done, result_band, result_fine,
    output start, fine_meas
  );
endinterface

// [rtl/monitor_search.sv]
// descending band and step search of the battery voltage monitor
`timescale 1ns/1ns
module monitor_search
  import charger_regs_pkg::*;
(
  monitor_if.search m
);
  search_state_type state_q;
  logic [4:0]       cnt_q;

  // ****************************************************************
  // search sequence
  // ****************************************************************
  always_ff @(posedge m.clk) begin
    if (m.rst) begin
      state_q <= S_IDLE;
      cnt_q   <= 5'h00;
      m.band  <= BAND_TOP;
      m.busy  <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (m.start) begin
            m.band  <= BAND_TOP; // RULE7
            cnt_q   <= 5'h00;
            m.busy  <= 1'b1;
            state_q <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (cnt_q == SETTLE_LAST) begin
            state_q <= S_SAMPLE;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        S_SAMPLE: begin
          if (m.fine_meas != FINE_NONE || m.band == BAND_BOTTOM) begin
            m.busy  <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            m.band  <= m.band - 2'h1; // RULE7
            cnt_q   <= 5'h00;
            state_q <= S_SETTLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // result capture, only at the end of a search
  // ****************************************************************
  always_ff @(posedge m.clk) begin
    if (m.rst) begin
      m.done        <= 1'b0;
      m.result_band <= BAND_BOTTOM;
      m.result_fine <= FINE_NONE;
    end else begin
      m.done <= 1'b0;
      if (state_q == S_SAMPLE &&
          (m.fine_meas != FINE_NONE || m.band == BAND_BOTTOM)) begin
        // bottom band with no step leaves 00 000
        m.done        <= 1'b1; // RULE13
        m.result_band <= m.band; // RULE8
        m.result_fine <= m.fine_meas; // RULE8
      end
    end
  end

  AST_SEARCH_TOP: assert property (@(posedge m.clk) disable iff (m.rst) // RULE7
    state_q == S_IDLE && m.start |=> m.band == BAND_TOP && m.busy)
    else $error("search did not start at top band");

  AST_SEARCH_STEP: assert property (@(posedge m.clk) disable iff (m.rst) // RULE7
    state_q == S_SAMPLE && m.fine_meas == FINE_NONE &&
    m.band != BAND_BOTTOM |=> m.band == $past(m.band) - 2'h1)
    else $error("search did not step down one band");

  AST_SEARCH_FLOOR: assert property (@(posedge m.clk) disable iff (m.rst) // RULE8
    state_q == S_SAMPLE && m.fine_meas == FINE_NONE &&
    m.band == BAND_BOTTOM |=> m.done && m.result_band == BAND_BOTTOM &&
    m.result_fine == FINE_NONE)
    else $error("empty search did not report 00 000");

  AST_RESULT_HOLD: assert property (@(posedge m.clk) disable iff (m.rst) // RULE13
    !m.done && !$past(m.rst) |-> $stable(m.result_band) &&
    $stable(m.result_fine))
    else $error("monitor result changed outside completion");
endmodule

// [rtl/safety_timer.sv]
// fast-charge safety timer with optional half-speed counting
`timescale 1ns/1ns
module safety_timer
  import charger_regs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       active_i,
  input  wire logic       cccv_i,
  input  wire logic       half_en_i,
  input  wire logic [1:0] sel_i,
  output logic            expired_o
);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  logic [TICK_W-1:0] pre_q;
  logic              half_q;
  logic [15:0]       sec_q;
  logic [15:0]       limit;
  logic              tick;
  logic              slow;
  logic              advance;
  logic              running;

  assign tick    = (pre_q == TICK_LAST);
  assign slow    = half_en_i && !cccv_i; // RULE11
  assign advance = tick && (!slow || half_q); // RULE11
  assign running = active_i && sel_i != TMR_OFF; // RULE12

  always_comb begin
    case (sel_i)
      TMR_30MIN: limit = LIMIT_30MIN_S; // RULE12
      TMR_3H:    limit = LIMIT_3H_S; // RULE12
      TMR_9H:    limit = LIMIT_9H_S; // RULE12
      default:   limit = 16'hFFFF;
    endcase
  end

  // ****************************************************************
  // prescaler and half-rate gate
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || !running) begin
      pre_q <= '0;
    end else if (tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !running || !slow) begin
      half_q <= 1'b0;
    end else if (tick) begin
      half_q <= !half_q;
    end
  end

  // ****************************************************************
  // elapsed seconds and expiry
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || !running) begin
      sec_q <= 16'h0000;
    end else if (advance && !expired_o) begin
      sec_q <= sec_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !running) begin
      expired_o <= 1'b0;
    end else if (sec_q >= limit) begin
      expired_o <= 1'b1;
    end
  end

  AST_HALF_RATE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    running && tick && slow && !half_q |-> ##1 sec_q == $past(sec_q))
    else $error("slowed timer advanced on a skipped tick");

  AST_TMR_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    sel_i == TMR_OFF |=> !expired_o)
    else $error("disabled safety timer expired");

  AST_TMR_LIMIT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    $rose(expired_o) |-> $past(sec_q) >= $past(limit))
    else $error("safety timer expired before its limit");
endmodule

// [rtl/charger_limit_monitor_regs.sv]
// register bank for input limit, lockout, battery monitor and timers
`timescale 1ns/1ns

// How it works
// RULE1 - writing one to top bit restores defaults
// RULE2 - input limit is 50 mA plus code steps
// RULE3 - lockout code maps to listed voltages
// RULE4 - monitor request write starts search, reads zero
// RULE5 - coarse band field reports battery band
// RULE6 - fine step field reports position in band
// RULE7 - search starts at top band, steps down
// RULE8 - empty search reports 00 000
// RULE9 - voltage loop top bit zero enables regulation
// RULE10 - loop threshold is 4.2 V plus 100 mV steps
// RULE11 - half-speed bit halves timer outside CC/CV
// RULE12 - timer select picks limit or disables
// RULE13 - software search updates fields only when done
// RULE14 - unused bits read zero, ignore writes
module charger_limit_monitor_regs
  import charger_regs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  input  wire logic [7:0]  REG_WDATA_I,
  output logic      [7:0]  REG_RDATA_O,
  output logic             REG_RVALID_O,
  input  wire logic        LOW_POWER_REQ_I,
  input  wire logic [2:0]  MON_FINE_I,
  output logic      [1:0]  MON_BAND_O,
  output logic             MON_BUSY_O,
  input  wire logic        CHARGE_ACTIVE_I,
  input  wire logic        CHARGE_CCCV_I,
  output logic      [2:0]  INPUT_LIMIT_CODE_O,
  output logic      [9:0]  INPUT_LIMIT_MA_O,
  output logic      [2:0]  LOCKOUT_CODE_O,
  output logic      [11:0] LOCKOUT_MV_O,
  output logic             VIN_LOOP_DISABLE_O,
  output logic      [12:0] VIN_LOOP_MV_O,
  output logic             SAFETY_EXPIRED_O
);
  // ****************************************************************
  // storage and decode
  // ****************************************************************
  logic [7:0]  limit_reg_q;
  logic [7:0]  vin_reg_q;
  logic        soft_rst_q;
  logic        search_rst;
  logic        wr_limit;
  logic        wr_monitor;
  logic        wr_vin;
  logic        soft_hit;
  logic        mon_req;
  logic [2:0]  ilim_code;
  logic [2:0]  uvlo_code;
  logic [2:0]  vloop_code;
  logic [11:0] uvlo_mv_d;
  logic [7:0]  rdata_d;

  assign wr_limit   = REG_WR_I && REG_ADDR_I == LIMIT_REG_ADDR;
  assign wr_monitor = REG_WR_I && REG_ADDR_I == MONITOR_REG_ADDR;
  assign wr_vin     = REG_WR_I && REG_ADDR_I == VINREG_ADDR;
  assign soft_hit   = wr_limit && REG_WDATA_I[SOFT_RST_BIT]; // RULE1
  assign mon_req    = wr_monitor && REG_WDATA_I[MON_REQ_BIT]; // RULE4
  assign search_rst = SYS_RST_I || soft_rst_q;

  assign ilim_code  = limit_reg_q[ILIM_LSB +: 3];
  assign uvlo_code  = limit_reg_q[UVLO_LSB +: 3];
  assign vloop_code = vin_reg_q[VLOOP_LSB +: 3];

  monitor_if mon (
    .clk (CLK_SYS_I),
    .rst (search_rst)
  );

  // ****************************************************************
  // register writes
  // ****************************************************************
  // soft reset acts on the writing edge itself, so the next read
  // already sees defaults; the search is cleared one cycle later
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I || soft_hit) begin
      limit_reg_q <= LIMIT_REG_RST; // RULE1
    end else if (wr_limit) begin
      limit_reg_q <= REG_WDATA_I & LIMIT_WR_MASK; // RULE14
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I || soft_hit) begin
      vin_reg_q <= VINREG_RST; // RULE1
    end else if (wr_vin) begin
      vin_reg_q <= REG_WDATA_I & VINREG_WR_MASK; // RULE14
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= soft_hit; // RULE1
    end
  end

  // ****************************************************************
  // battery monitor requests
  // ****************************************************************
  // a request while a search runs is dropped; the running search
  // already yields a fresh reading
  assign mon.start     = mon_req || LOW_POWER_REQ_I; // RULE13
  assign mon.fine_meas = MON_FINE_I;

  monitor_search u_search (
    .m (mon.search)
  );

  assign MON_BAND_O = mon.band;
  assign MON_BUSY_O = mon.busy;

  // ****************************************************************
  // safety timer
  // ****************************************************************
  safety_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk_i     (CLK_SYS_I),
    .rst_i     (SYS_RST_I),
    .active_i  (CHARGE_ACTIVE_I),
    .cccv_i    (CHARGE_CCCV_I),
    .half_en_i (vin_reg_q[HALF_BIT]), // RULE11
    .sel_i     (vin_reg_q[TMR_LSB +: 2]), // RULE12
    .expired_o (SAFETY_EXPIRED_O)
  );

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    case (REG_ADDR_I)
      LIMIT_REG_ADDR: begin
        rdata_d = limit_reg_q & LIMIT_WR_MASK; // RULE1
      end
      MONITOR_REG_ADDR: begin
        rdata_d = 8'h00; // RULE4
        rdata_d[BAND_LSB +: 2] = mon.result_band; // RULE5
        rdata_d[FINE_LSB +: 3] = mon.result_fine; // RULE6
      end
      VINREG_ADDR: begin
        rdata_d = vin_reg_q & VINREG_WR_MASK; // RULE14
      end
      default: begin
        rdata_d = READ_UNMAPPED;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O  <= 8'h00;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= rdata_d;
      end
    end
  end

  // ****************************************************************
  // decoded settings for the analog loops
  // ****************************************************************
  always_comb begin
    case (uvlo_code)
      UVLO_C3000:  uvlo_mv_d = UVLO_3000_MV; // RULE3
      UVLO_C2800:  uvlo_mv_d = UVLO_2800_MV; // RULE3
      UVLO_C2600:  uvlo_mv_d = UVLO_2600_MV; // RULE3
      UVLO_C2400:  uvlo_mv_d = UVLO_2400_MV; // RULE3
      UVLO_C2200A: uvlo_mv_d = UVLO_2200_MV; // RULE3
      UVLO_C2200B: uvlo_mv_d = UVLO_2200_MV; // RULE3
      default:     uvlo_mv_d = UVLO_RSVD_MV;
    endcase
  end

  // one cycle behind the register; the loops are far slower
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      INPUT_LIMIT_CODE_O <= LIMIT_REG_RST[ILIM_LSB +: 3];
      INPUT_LIMIT_MA_O   <= ILIM_BASE_MA + ILIM_STEP_MA *
                            10'(LIMIT_REG_RST[ILIM_LSB +: 3]);
    end else begin
      INPUT_LIMIT_CODE_O <= ilim_code;
      INPUT_LIMIT_MA_O   <= ILIM_BASE_MA + ILIM_STEP_MA *
                            10'(ilim_code); // RULE2
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      LOCKOUT_CODE_O <= LIMIT_REG_RST[UVLO_LSB +: 3];
      LOCKOUT_MV_O   <= UVLO_3000_MV;
    end else begin
      LOCKOUT_CODE_O <= uvlo_code;
      LOCKOUT_MV_O   <= uvlo_mv_d; // RULE3
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      VIN_LOOP_DISABLE_O <= VINREG_RST[VLOOP_OFF_BIT];
      VIN_LOOP_MV_O      <= VLOOP_BASE_MV + VLOOP_STEP_MV *
                            13'(VINREG_RST[VLOOP_LSB +: 3]);
    end else begin
      VIN_LOOP_DISABLE_O <= vin_reg_q[VLOOP_OFF_BIT]; // RULE9
      VIN_LOOP_MV_O      <= VLOOP_BASE_MV + VLOOP_STEP_MV *
                            13'(vloop_code); // RULE10
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_SOFT_RESET: assert property (@(posedge CLK_SYS_I) // RULE1
    disable iff (SYS_RST_I)
    soft_hit |=> limit_reg_q == LIMIT_REG_RST && vin_reg_q == VINREG_RST)
    else $error("soft reset did not restore defaults");

  AST_SOFT_RESET_READ: assert property (@(posedge CLK_SYS_I) // RULE1
    disable iff (SYS_RST_I)
    REG_RD_I && REG_ADDR_I == LIMIT_REG_ADDR |=> !REG_RDATA_O[SOFT_RST_BIT])
    else $error("soft reset bit read back as one");

  AST_ILIM: assert property (@(posedge CLK_SYS_I) // RULE2
    disable iff (SYS_RST_I)
    ##1 INPUT_LIMIT_MA_O == 10'(50 + 50 * $past(ilim_code)))
    else $error("input limit decode wrong");

  AST_UVLO_3V: assert property (@(posedge CLK_SYS_I) // RULE3
    disable iff (SYS_RST_I)
    uvlo_code == UVLO_C3000 |=> LOCKOUT_MV_O == UVLO_3000_MV)
    else $error("lockout code 010 not 3.0 V");

  AST_REQ_READ_ZERO: assert property (@(posedge CLK_SYS_I) // RULE4
    disable iff (SYS_RST_I)
    REG_RD_I && REG_ADDR_I == MONITOR_REG_ADDR |=>
    !REG_RDATA_O[MON_REQ_BIT] && REG_RDATA_O[1:0] == 2'h0)
    else $error("monitor request or unused bits read nonzero");

  AST_REQ_STARTS: assert property (@(posedge CLK_SYS_I) // RULE4
    disable iff (search_rst)
    mon_req && !mon.busy |=> mon.busy)
    else $error("monitor request did not start a search");

  AST_BAND_FIELD: assert property (@(posedge CLK_SYS_I) // RULE5
    disable iff (SYS_RST_I)
    REG_RD_I && REG_ADDR_I == MONITOR_REG_ADDR |=>
    REG_RDATA_O[BAND_LSB +: 2] == $past(mon.result_band) &&
    REG_RDATA_O[FINE_LSB +: 3] == $past(mon.result_fine))
    else $error("monitor fields not reported");

  AST_VLOOP: assert property (@(posedge CLK_SYS_I) // RULE9
    disable iff (SYS_RST_I)
    ##1 VIN_LOOP_DISABLE_O == $past(vin_reg_q[VLOOP_OFF_BIT]))
    else $error("voltage loop enable not following register");

  AST_VLOOP_MV: assert property (@(posedge CLK_SYS_I) // RULE10
    disable iff (SYS_RST_I)
    ##1 VIN_LOOP_MV_O == 13'(4200 + 100 * $past(vloop_code)))
    else $error("voltage loop threshold decode wrong");

  AST_NA_ZERO: assert property (@(posedge CLK_SYS_I) // RULE14
    disable iff (SYS_RST_I)
    REG_RD_I && (REG_ADDR_I == LIMIT_REG_ADDR ||
    REG_ADDR_I == VINREG_ADDR) |=> (REG_RDATA_O & ($past(REG_ADDR_I) ==
    VINREG_ADDR ? ~VINREG_WR_MASK : ~LIMIT_WR_MASK)) == 8'h00)
    else $error("unused bit read nonzero");

  AST_UNMAPPED_READ: assert property (@(posedge CLK_SYS_I) // RULE14
    disable iff (SYS_RST_I)
    REG_RD_I && REG_ADDR_I != LIMIT_REG_ADDR &&
    REG_ADDR_I != MONITOR_REG_ADDR && REG_ADDR_I != VINREG_ADDR |=>
    REG_RDATA_O == 8'h00)
    else $error("unmapped address read nonzero");

  AST_ILIM_CODE: assert property (@(posedge CLK_SYS_I) // RULE2
    disable iff (SYS_RST_I)
    ##1 INPUT_LIMIT_CODE_O == $past(limit_reg_q[ILIM_LSB +: 3]))
    else $error("input limit code not following register");

  AST_UVLO_CODE: assert property (@(posedge CLK_SYS_I) // RULE3
    disable iff (SYS_RST_I)
    ##1 LOCKOUT_CODE_O == $past(limit_reg_q[UVLO_LSB +: 3]))
    else $error("lockout code not following register");

  // both top codes share one threshold; no code above them exists
  AST_UVLO_LOW: assert property (@(posedge CLK_SYS_I) // RULE3
    disable iff (SYS_RST_I)
    uvlo_code == UVLO_C2200A || uvlo_code == UVLO_C2200B |=>
    LOCKOUT_MV_O == 12'h898)
    else $error("lockout codes 110 and 111 not 2.2 V");

  AST_SOFT_SEARCH: assert property (@(posedge CLK_SYS_I) // RULE1
    disable iff (SYS_RST_I)
    soft_hit |-> ##2 !mon.busy && mon.result_band == BAND_BOTTOM &&
    mon.result_fine == FINE_NONE)
    else $error("soft reset did not clear the monitor");
endmodule

// [dv/charger_limit_monitor_regs_tb.sv]
// self-checking testbench for the charger register bank
`timescale 1ns/1ns
module charger_limit_monitor_regs_tb
  import charger_regs_pkg::*;
;
  // ****************************************************************
  // signals and design under test
  // ****************************************************************
  logic        clk, rst, wr, rd, lp, active, cccv;
  logic [7:0]  addr, wdata, rdata, rd_v, mid_v;
  logic [2:0]  fine, fv;
  logic [1:0]  band, tgt;
  logic        rvalid, busy, vdis, expired;
  logic [2:0]  ilim_code, lock_code;
  logic [9:0]  ilim_ma;
  logic [11:0] lock_mv;
  logic [12:0] vloop_mv;
  int          err_total, compares;
  logic [11:0] lk [8] = '{12'h000, 12'h000, 12'hBB8, 12'hAF0,
                          12'hA28, 12'h960, 12'h898, 12'h898};
  logic [1:0]  bt [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
  logic [2:0]  ft [5] = '{3'h7, 3'h6, 3'h3, 3'h2, 3'h1};

  charger_limit_monitor_regs #(.TICK_CYCLES(4)) charger_limit_monitor_regs_i (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .LOW_POWER_REQ_I(lp), .MON_FINE_I(fine),
    .MON_BAND_O(band), .MON_BUSY_O(busy), .CHARGE_ACTIVE_I(active),
    .CHARGE_CCCV_I(cccv), .INPUT_LIMIT_CODE_O(ilim_code),
    .INPUT_LIMIT_MA_O(ilim_ma), .LOCKOUT_CODE_O(lock_code),
    .LOCKOUT_MV_O(lock_mv), .VIN_LOOP_DISABLE_O(vdis),
    .VIN_LOOP_MV_O(vloop_mv), .SAFETY_EXPIRED_O(expired));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // comparator stand-in: answers only for the band the search is testing
  always @(posedge clk) begin
    fine <= (band === tgt) ? fv : 3'h0;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    d = rdata;
  endtask

  // decoded outputs lag the register write by one edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up;
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; lp = 1'b0; active = 1'b0;
    cccv = 1'b0; addr = 8'h00; wdata = 8'h00;
    fv = 3'h0; tgt = 2'h0; err_total = 0; compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h09, rd_v); chk("reg09 rst", 16'h000A, {8'h00, rd_v});
    rd_reg(8'h0B, rd_v); chk("reg0B rst", 16'h004A, {8'h00, rd_v});
    rd_reg(8'h20, rd_v); chk("unmapped", 16'h0000, {8'h00, rd_v});
    // every limit and lockout code, reserved lockout codes included
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h09, {2'h0, 3'(c), 3'(c)});
      settle();
      chk("ilim ma", 16'(50 + 50 * c), {6'h00, ilim_ma});
      chk("lock mv", {4'h0, lk[c]}, {4'h0, lock_mv});
      chk("ilim code", 16'(c), {13'h0000, ilim_code});
      chk("lock code", 16'(c), {13'h0000, lock_code});
      wr_reg(8'h0B, {1'(c), 3'(c), 4'h0});
      settle();
      chk("loop off", 16'(c % 2), {15'h0000, vdis});
      chk("loop mv", 16'(4200 + 100 * c), {3'h0, vloop_mv});
    end
    wr_reg(8'h09, 8'h7F);
    rd_reg(8'h09, rd_v); chk("reg09 na", 16'h003F, {8'h00, rd_v});
    wr_reg(8'h0B, 8'hFF);
    rd_reg(8'h0B, rd_v); chk("reg0B na", 16'h00FE, {8'h00, rd_v});
    // searches ending in each band, started by write or low-power request
    rd_v = 8'h00;
    for (int k = 0; k < 6; k++) begin
      tgt <= (k < 5) ? bt[k] : 2'h0;
      fv <= (k < 5) ? ft[k] : 3'h0;
      if (k % 2 == 0) wr_reg(8'h0A, 8'h80);
      else begin
        @(posedge clk); lp <= 1'b1;
        @(posedge clk); lp <= 1'b0;
      end
      #1;
      chk("busy", 16'h0001, {15'h0000, busy});
      chk("first band", 16'h0003, {14'h0000, band});
      rd_reg(8'h0A, mid_v);
      chk("mid search", {8'h00, rd_v}, {8'h00, mid_v});
      for (int n = 0; n < 200 && busy !== 1'b0; n++) @(posedge clk);
      if (busy !== 1'b0) chk("search end", 16'h0000, 16'h0001);
      rd_reg(8'h0A, rd_v);
      if (k < 5)
        chk("result", {8'h00, 1'b0, bt[k], ft[k], 2'h0}, {8'h00, rd_v});
      else
        chk("empty", 16'h0000, {8'h00, rd_v});
      if (k == 4) begin
        wr_reg(8'h0B, 8'h11);
        wr_reg(8'h09, 8'h80);
        rd_reg(8'h09, rd_v); chk("soft 09", 16'h000A, {8'h00, rd_v});
        rd_reg(8'h0B, rd_v); chk("soft 0B", 16'h004A, {8'h00, rd_v});
        rd_reg(8'h0A, rd_v); chk("soft 0A", 16'h0000, {8'h00, rd_v});
        settle();
        chk("soft ilim", 16'h0064, {6'h00, ilim_ma});
      end
    end
    // 30 minute limit: full rate, half rate outside CC/CV, full in CC/CV
    wr_reg(8'h0B, 8'h40);
    for (int h = 0; h < 3; h++) begin
      if (h == 1) wr_reg(8'h0B, 8'h48);
      @(posedge clk); active <= 1'b1; cccv <= (h == 2);
      repeat (7160 + (h == 1) * 7200) @(posedge clk);
      #1; chk("early", 16'h0000, {15'h0000, expired});
      repeat (80) @(posedge clk);
      #1; chk("expired", 16'h0001, {15'h0000, expired});
      if (h == 2) begin
        wr_reg(8'h0B, 8'h4E);
        settle();
        chk("timer off", 16'h0000, {15'h0000, expired});
      end
      @(posedge clk); active <= 1'b0;
      settle();
    end
    wrap_up();
  end

  // watchdog sized well above the longest path through the tests
  initial begin
    #(60000 * 50);
    err_total++;
    wrap_up();
  end
endmodule
